//--- stg_evt_model.sv
// stg_evt_model: event detectors and frame source beside the gate
// assumes the bench requests hits just after a rising edge of mclk
`timescale 1ns/1ns
`default_nettype none
module stg_evt_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // bench request, detector outputs and frame source output
    input  wire logic [5:0] fire,
    output logic      [5:0] event_hits,
    output logic            frame_valid
);
    // hits are one-cycle pulses; event-cycle tracing offers a frame
    // every cycle, so a stray write shows at once on trace_wr
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            event_hits  <= 6'h00;
            frame_valid <= 1'b0;
        end else begin
            event_hits  <= fire;
            frame_valid <= 1'b1;
        end
    end
endmodule // stg_evt_model
`default_nettype wire

//--- stg_gate.sv
// stg_gate: sectional trace qualifier of the real-time tracer
// assumes same-clock event hits and a one-cycle-latency register port
//
// Contract
// - gate goes active on a start event, idle on an end event
// - in sectional mode frames are written only while the gate is active; other modes write every frame
// - start detect is OR of all selected start events
// - end detect is OR of all selected end events
// - mismatched pairing is stored, flagged, and the end event can no longer close the gate
// - off selection disables the point; both default off after reset
// - start and end act only in sectional condition mode
// - data-access events 3 and 4 unusable while on external output
// - fetch end on a multi-byte instruction may lose the last frame
// - start and end selections read back unchanged
// - sectional mode refused with machine-cycle trace mode
`timescale 1ns/1ns
`default_nettype none
module stg_gate (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // emulator side
    input  wire logic       emu_run,
    input  wire logic [5:0] event_hits,
    input  wire logic       frame_valid,
    input  wire logic       frame_multibyte,
    // trace memory side
    output logic            trace_wr,
    output logic            gate_active
);
    typedef enum logic [1:0] {
        STG_IDLE   = 2'b01,
        STG_ACTIVE = 2'b10
    } stg_state_e;

    stg_state_e state_q;
    logic [5:0] start_q;
    logic [5:0] end_q;
    logic [3:0] mode_q;
    logic [7:0] rdata_q;
    logic       run_q;
    logic       lastrisk_q;
    logic       mismatch;
    logic       sect_on;
    logic       start_ev;
    logic       end_ev;
    logic [1:0] cond_wr;
    logic [1:0] cond_req;
    logic [3:0] status;

    stg_if sbus ();
    assign sbus.hits       = event_hits;
    assign sbus.start_sel  = start_q;
    assign sbus.end_sel    = end_q;
    assign sbus.block_da34 = mode_q[stg_pkg::MODE_OUT_BIT];

    stg_sel u_sel (
        .bus (sbus)
    );

    // selections are stored even when mismatched; only flagged
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_q <= stg_pkg::SEL_OFF;
            end_q   <= stg_pkg::SEL_OFF;
        end else if (reg_wr) begin
            if (reg_addr == stg_pkg::OFS_START)
                start_q <= reg_wdata[5:0];
            if (reg_addr == stg_pkg::OFS_END)
                end_q <= reg_wdata[5:0];
        end
    end

    // a sectional request under machine-cycle mode falls back to ALL
    assign cond_req = reg_wdata[stg_pkg::MODE_COND_LSB +: 2];
    always_comb begin
        cond_wr = cond_req;
        if (cond_req == stg_pkg::COND_SECT
            && !reg_wdata[stg_pkg::MODE_CYC_BIT])
            cond_wr = stg_pkg::COND_ALL;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            mode_q <= stg_pkg::MODE_RESET;
        else if (reg_wr && reg_addr == stg_pkg::OFS_MODE)
            mode_q <= {reg_wdata[3:2], cond_wr};
    end

    // class check: a mixed selection or a cross-class pairing
    always_comb begin
        mismatch = 1'b0;
        if (((start_q & stg_pkg::DA_MASK) != 6'h00)
            && ((start_q & stg_pkg::FE_MASK) != 6'h00))
            mismatch = 1'b1;
        if (((end_q & stg_pkg::DA_MASK) != 6'h00)
            && ((end_q & stg_pkg::FE_MASK) != 6'h00))
            mismatch = 1'b1;
        if (((start_q & stg_pkg::DA_MASK) != 6'h00)
            && ((end_q & stg_pkg::FE_MASK) != 6'h00))
            mismatch = 1'b1;
        if (((start_q & stg_pkg::FE_MASK) != 6'h00)
            && ((end_q & stg_pkg::DA_MASK) != 6'h00))
            mismatch = 1'b1;
    end

    assign sect_on = mode_q[stg_pkg::MODE_COND_LSB +: 2]
                     == stg_pkg::COND_SECT;
    assign start_ev = sect_on && sbus.start_hit;
    // no valid deactivation exists for a mismatched pairing
    assign end_ev   = sect_on && sbus.end_hit && !mismatch;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            run_q <= 1'b0;
        else
            run_q <= emu_run;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= STG_IDLE;
        end else if (!emu_run || (emu_run && !run_q) || !sect_on) begin
            state_q <= STG_IDLE;
        end else begin
            case (state_q)
                STG_IDLE:
                    if (start_ev)
                        state_q <= STG_ACTIVE;
                STG_ACTIVE:
                    if (end_ev)
                        state_q <= STG_IDLE;
                default:
                    state_q <= STG_IDLE;
            endcase
        end
    end

    assign gate_active = (state_q == STG_ACTIVE);
    // in other condition modes the gate does not restrict writes
    assign trace_wr = frame_valid && emu_run
                      && (!sect_on || gate_active);

    // flag a possible loss of the closing fetch frame of a multi-byte instruction; cleared on the next start
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            lastrisk_q <= 1'b0;
        else if (gate_active && end_ev && frame_multibyte
                 && ((end_q & stg_pkg::FE_MASK) != 6'h00))
            lastrisk_q <= 1'b1;
        else if (start_ev && !gate_active)
            lastrisk_q <= 1'b0;
    end

    // status word for software; bit positions kept in the package
    always_comb begin
        status = 4'h0;
        status[stg_pkg::ST_ACTIVE]   = gate_active;
        status[stg_pkg::ST_MISMATCH] = mismatch;
        status[stg_pkg::ST_ARMED]    = sect_on;
        status[stg_pkg::ST_LASTRISK] = lastrisk_q;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                stg_pkg::OFS_START: rdata_q <= {2'h0, start_q};
                stg_pkg::OFS_END:   rdata_q <= {2'h0, end_q};
                stg_pkg::OFS_MODE:  rdata_q <= {4'h0, mode_q};
                stg_pkg::OFS_STAT:  rdata_q <= {4'h0, status};
                default:            rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // assertions
    property p_open;
        @(posedge mclk) disable iff (rst)
        (state_q == STG_IDLE && emu_run && run_q && sect_on && start_ev)
        |=> gate_active;
    endproperty
    a_open: assert property (p_open) else $error("gate did not open");

    property p_close;
        @(posedge mclk) disable iff (rst)
        (gate_active && emu_run && sect_on && end_ev) |=> !gate_active;
    endproperty
    a_close: assert property (p_close) else $error("gate did not close");

    property p_wr_idle;
        @(posedge mclk) disable iff (rst)
        (sect_on && !gate_active) |-> !trace_wr;
    endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("write while idle");

    property p_mode_inert;
        @(posedge mclk) disable iff (rst)
        !sect_on |=> !gate_active;
    endproperty
    a_mode_inert: assert property (p_mode_inert)
        else $error("gate active outside sectional mode");

    property p_mismatch_hold;
        @(posedge mclk) disable iff (rst)
        (gate_active && mismatch && emu_run && sect_on) |=> gate_active;
    endproperty
    a_mismatch_hold: assert property (p_mismatch_hold)
        else $error("mismatched pairing closed gate");

    property p_da34;
        @(posedge mclk) disable iff (rst)
        (mode_q[stg_pkg::MODE_OUT_BIT]
         && (event_hits & ~stg_pkg::DA34_MASK & start_q) == 6'h00)
        |-> !sbus.start_hit;
    endproperty
    a_da34: assert property (p_da34) else $error("blocked event started");

    property p_readback;
        @(posedge mclk) disable iff (rst)
        (reg_rd && reg_addr == stg_pkg::OFS_START && !reg_wr)
        |=> reg_rdata == {2'h0, $past(start_q)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("start readback wrong");

    property p_run_start;
        @(posedge mclk) disable iff (rst)
        (emu_run && !run_q) |=> !gate_active;
    endproperty
    a_run_start: assert property (p_run_start)
        else $error("run did not start idle");

    property p_no_mcyc;
        @(posedge mclk) disable iff (rst)
        sect_on |-> mode_q[stg_pkg::MODE_CYC_BIT];
    endproperty
    a_no_mcyc: assert property (p_no_mcyc)
        else $error("sectional with machine cycle");

    property p_start_any;
        @(posedge mclk) disable iff (rst)
        (!mode_q[stg_pkg::MODE_OUT_BIT] && (event_hits & start_q) != 6'h00)
        |-> sbus.start_hit;
    endproperty
    a_start_any: assert property (p_start_any)
        else $error("selected start event not seen");

    property p_end_any;
        @(posedge mclk) disable iff (rst)
        (!mode_q[stg_pkg::MODE_OUT_BIT] && (event_hits & end_q) != 6'h00)
        |-> sbus.end_hit;
    endproperty
    a_end_any: assert property (p_end_any)
        else $error("selected end event not seen");

    property p_lastrisk;
        @(posedge mclk) disable iff (rst)
        (gate_active && end_ev && frame_multibyte
         && (end_q & stg_pkg::FE_MASK) != 6'h00) |=> lastrisk_q;
    endproperty
    a_lastrisk: assert property (p_lastrisk)
        else $error("last frame risk not flagged");

    property p_sel_hold;
        @(posedge mclk) disable iff (rst)
        (reg_rd && !reg_wr) |=> $stable(start_q) && $stable(end_q);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("readback changed a selection");

    property p_mode_store;
        @(posedge mclk) disable iff (rst)
        (reg_wr && reg_addr == stg_pkg::OFS_MODE
         && reg_wdata[stg_pkg::MODE_COND_LSB +: 2] == stg_pkg::COND_SECT
         && !reg_wdata[stg_pkg::MODE_CYC_BIT])
        |=> mode_q[stg_pkg::MODE_COND_LSB +: 2] == stg_pkg::COND_ALL;
    endproperty
    a_mode_store: assert property (p_mode_store)
        else $error("sectional stored under machine cycle");

    c_open: cover property (@(posedge mclk) disable iff (rst)
        !gate_active ##1 gate_active);
    c_close: cover property (@(posedge mclk) disable iff (rst)
        gate_active ##1 !gate_active);
    c_mismatch: cover property (@(posedge mclk) disable iff (rst)
        mismatch && sect_on);
    c_lastrisk: cover property (@(posedge mclk) disable iff (rst)
        $rose(lastrisk_q));
    c_blocked: cover property (@(posedge mclk) disable iff (rst)
        mode_q[stg_pkg::MODE_OUT_BIT] && event_hits[3:2] != 2'h0);
endmodule // stg_gate
`default_nettype wire

//--- stg_gate_tb_top.sv
// stg_gate_tb_top: self-checking bench for the sectional trace gate
// assumes stg_pkg, stg_if, stg_sel, stg_gate, stg_evt_model compiled
`timescale 1ns/1ns
`default_nettype none
module stg_gate_tb_top;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       emu_run = 1'b0;
    logic [5:0] fire = 6'h00;
    logic [5:0] event_hits;
    logic       frame_valid;
    logic       frame_multibyte = 1'b0;
    logic       trace_wr;
    logic       gate_active;
    int         err_total = 0;
    int         comparisons = 0;

    always #5 mclk = ~mclk;

    stg_evt_model model (.mclk(mclk), .rst(rst), .fire(fire),
        .event_hits(event_hits), .frame_valid(frame_valid));
    stg_gate uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .emu_run(emu_run),
        .event_hits(event_hits), .frame_valid(frame_valid),
        .frame_multibyte(frame_multibyte), .trace_wr(trace_wr),
        .gate_active(gate_active));

    task automatic end_sim;
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [3:0] a,
                      input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask
    // hit reaches the gate one cycle late; gate answers one cycle on
    task automatic hit(input logic [5:0] h);
        @(posedge mclk);
        fire <= h;
        @(posedge mclk);
        fire <= 6'h00;
        @(posedge mclk);
        #1;
    endtask
    task automatic gs(input logic [1:0] e);
        chk("trace_wr,gate_active", {6'h00, e},
            {6'h00, trace_wr, gate_active});
    endtask
    // a fresh run: emu_run dropped while the selections change
    task automatic setup(input logic [5:0] s, input logic [5:0] e,
                         input logic [3:0] m);
        @(posedge mclk);
        emu_run <= 1'b0;
        wr(stg_pkg::OFS_START, {2'h0, s});
        wr(stg_pkg::OFS_END, {2'h0, e});
        wr(stg_pkg::OFS_MODE, {4'h0, m});
        @(posedge mclk);
        emu_run <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic t_reset;
        rd("start", stg_pkg::OFS_START, 8'h00);
        rd("end", stg_pkg::OFS_END, 8'h00);
        rd("mode", stg_pkg::OFS_MODE, 8'h00);
        rd("status", stg_pkg::OFS_STAT, 8'h00);
        rd("unmapped", 4'h7, 8'h00);
    endtask
    task automatic t_readback;
        wr(stg_pkg::OFS_START, 8'hC3);
        wr(stg_pkg::OFS_END, 8'h30);
        rd("start", stg_pkg::OFS_START, 8'h03);
        rd("end", stg_pkg::OFS_END, 8'h30);
        rd("start", stg_pkg::OFS_START, 8'h03);
        wr(stg_pkg::OFS_MODE, 8'h02);
        rd("mode", stg_pkg::OFS_MODE, 8'h00);
    endtask
    task automatic t_data_section;
        setup(6'h03, 6'h0C, 4'h6);
        gs(2'b00);
        hit(6'h02);
        gs(2'b11);
        rd("status", stg_pkg::OFS_STAT, 8'h05);
        gs(2'b11);
        hit(6'h08);
        gs(2'b00);
        hit(6'h01);
        gs(2'b11);
        hit(6'h04);
        gs(2'b00);
    endtask
    task automatic t_fetch_section;
        setup(6'h10, 6'h20, 4'h6);
        @(posedge mclk);
        frame_multibyte <= 1'b1;
        hit(6'h10);
        gs(2'b11);
        hit(6'h20);
        gs(2'b00);
        rd("status", stg_pkg::OFS_STAT, 8'h0C);
        @(posedge mclk);
        frame_multibyte <= 1'b0;
    endtask
    // the risk flag of the fetch section stays set until the next opening
    task automatic t_mismatch;
        setup(6'h01, 6'h10, 4'h6);
        rd("status", stg_pkg::OFS_STAT, 8'h0E);
        hit(6'h01);
        hit(6'h10);
        gs(2'b11);
        rd("status", stg_pkg::OFS_STAT, 8'h07);
    endtask
    task automatic t_modes;
        // unconditional and qualified: every frame, gate stays shut
        for (int i = 4; i < 6; i++) begin
            setup(6'h01, 6'h02, i[3:0]);
            hit(6'h01);
            gs(2'b10);
        end
    endtask
    task automatic t_ext_off;
        setup(6'h0C, 6'h03, 4'hE);
        hit(6'h04);
        hit(6'h08);
        gs(2'b00);
        setup(6'h00, 6'h00, 4'h6);
        hit(6'h3F);
        gs(2'b00);
    endtask
    // second reset with the gate open: all back to off and idle
    task automatic t_rerst;
        setup(6'h03, 6'h0C, 4'h6);
        hit(6'h01);
        gs(2'b11);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd("start", stg_pkg::OFS_START, 8'h00);
        rd("end", stg_pkg::OFS_END, 8'h00);
        rd("mode", stg_pkg::OFS_MODE, 8'h00);
        gs(2'b10);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_readback();
        t_data_section();
        t_fetch_section();
        t_mismatch();
        t_modes();
        t_ext_off();
        t_rerst();
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        end_sim();
    end
endmodule // stg_gate_tb_top
`default_nettype wire

//--- stg_if.sv
// stg_if: event-hit carrier between the gate and its source selector
// assumes hits are synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
interface stg_if;
    logic [5:0] hits;
    logic [5:0] start_sel;
    logic [5:0] end_sel;
    logic       block_da34;
    logic       start_hit;
    logic       end_hit;
    modport sel (input hits, start_sel, end_sel, block_da34,
                 output start_hit, end_hit);
    modport gate (output hits, start_sel, end_sel, block_da34,
                  input start_hit, end_hit);
endinterface : stg_if
`default_nettype wire

//--- stg_pkg.sv
// stg_pkg: constants for the sectional trace gate
// assumes one clock domain, register port with one-cycle read latency
`default_nettype none
package stg_pkg;
    localparam int unsigned NUM_SRC = 6;
    // source select bit positions
    localparam int unsigned SRC_DA1 = 0;
    localparam int unsigned SRC_DA2 = 1;
    localparam int unsigned SRC_DA3 = 2;
    localparam int unsigned SRC_DA4 = 3;
    localparam int unsigned SRC_FE1 = 4;
    localparam int unsigned SRC_FE2 = 5;
    localparam logic [5:0] DA_MASK   = 6'h0F;
    localparam logic [5:0] FE_MASK   = 6'h30;
    localparam logic [5:0] DA34_MASK = 6'h0C;
    localparam logic [5:0] SEL_OFF   = 6'h00;
    // register offsets
    localparam logic [3:0] OFS_START = 4'h0;
    localparam logic [3:0] OFS_END   = 4'h1;
    localparam logic [3:0] OFS_MODE  = 4'h2;
    localparam logic [3:0] OFS_STAT  = 4'h3;
    // mode register fields
    localparam int unsigned MODE_COND_LSB = 0;
    localparam int unsigned MODE_CYC_BIT  = 2;
    localparam int unsigned MODE_OUT_BIT  = 3;
    localparam logic [1:0] COND_ALL   = 2'h0;
    localparam logic [1:0] COND_QUAL  = 2'h1;
    localparam logic [1:0] COND_SECT  = 2'h2;
    localparam logic [3:0] MODE_RESET = 4'h0;
    // status fields
    localparam int unsigned ST_ACTIVE   = 0;
    localparam int unsigned ST_MISMATCH = 1;
    localparam int unsigned ST_ARMED    = 2;
    localparam int unsigned ST_LASTRISK = 3;
endpackage : stg_pkg
`default_nettype wire

//--- stg_sel.sv
// stg_sel: ORs the selected event hits into start and end strobes
// assumes hits come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module stg_sel (
    stg_if.sel bus
);
    logic [5:0] avail;

    // event 3 and 4 withheld while driving the external output
    assign avail = bus.block_da34 ? ~stg_pkg::DA34_MASK : 6'h3F;
    assign bus.start_hit = |(bus.hits & bus.start_sel & avail);
    assign bus.end_hit   = |(bus.hits & bus.end_sel & avail);
endmodule // stg_sel
`default_nettype wire
